//--- samabc_pkg.sv
// constants, types and register map for the address map and boot config block
package samabc_pkg;
  // ==========================================================
  // address ranges, byte addresses, inclusive bounds
  localparam logic [31:0] CODE_LO = 32'h0000_0000;
  localparam logic [31:0] CODE_HI = 32'h0007_ffff;
  localparam logic [31:0] PROG_HI = 32'h0006_ffff;
  localparam logic [31:0] NVDATA_LO = 32'h0007_0000;
  localparam logic [31:0] NVDATA_HI = 32'h0007_7fff;
  localparam logic [31:0] BOOT_LO = 32'h0007_8000;
  localparam logic [31:0] BOOT_HI = 32'h0007_dfff;
  localparam logic [31:0] INFO_LO = 32'h0007_e000;
  localparam logic [31:0] INFO_USER_HI = 32'h0007_eeff;
  localparam logic [31:0] SRAM_LO = 32'h2000_0000;
  localparam logic [31:0] SRAM_LOW_HI = 32'h2000_5fff;
  localparam logic [31:0] SRAM_HIGH_LO = 32'h2000_6000;
  localparam logic [31:0] SRAM_HI = 32'h2000_67ff;
  localparam logic [31:0] PERIPH_LO = 32'h4000_0000;
  localparam logic [31:0] PERIPH_HI = 32'h4000_ffff;
  localparam logic [31:0] SCS_LO = 32'he000_c000;
  localparam logic [31:0] SCS_HI = 32'he000_ffff;
  // ==========================================================
  // configuration word fields
  localparam int CFG_RESET_BIT = 3;
  localparam int CFG_DEBUG_BIT = 4;
  localparam int CFG_BOOT_BIT = 6;
  localparam int CFG_READ_BIT = 7;
  localparam int CFG_SIG_LSB = 28;
  localparam logic [3:0] CFG_SIG_VALUE = 4'h4;
  // default word: every field at its documented default
  localparam logic [31:0] CFG_DEFAULT = 32'h4fff_0fd5;
  localparam int SEG_PINS = 24;
  // ==========================================================
  // register byte offsets
  localparam logic [3:0] REG_CFG_STATUS = 4'h0;
  localparam logic [3:0] REG_LCD_SEG = 4'h4;
  localparam logic [3:0] REG_ACCESS_STATUS = 4'h8;
  localparam logic [3:0] REG_ALT_ENABLE = 4'hc;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // address regions
  typedef enum logic [3:0] {
    RGN_HOLE, RGN_USER_PROG, RGN_USER_DATA, RGN_BOOT, RGN_CFG_INFO,
    RGN_SRAM_LOW, RGN_SRAM_HIGH, RGN_PERIPH, RGN_SCS
  } samabc_region_type;
  // register bus slave state
  typedef enum logic [1:0] {
    BUS_IDLE, BUS_WRESP, BUS_RRESP
  } samabc_bus_type;
  // decoded configuration fields
  typedef struct packed {
    logic valid;
    logic boot_en;
    logic read_en;
    logic debug_en;
    logic reset_en;
  } samabc_cfg_type;
endpackage

//--- samabc_top.sv
// address decoder, boot config decoder, pin ownership and register slave
//
// How it works
// [RL1] 0x0..0x7ffff is the 512KB code storage
// [RL2] 0x20000000..0x200067ff is the 26KB SRAM
// [RL3] 0x40000000..0x4000ffff is peripheral space
// [RL4] 0xe000c000..0xe000ffff is system control space
// [RL5] 0x0..0x6ffff is user program area
// [RL6] 0x70000..0x77fff is user nv data area
// [RL7] 0x78000..0x7dfff is boot program area
// [RL8] 0x7e000..0x7ffff is nv config info area
// [RL9] tools write only 0x7e000..0x7eeff of info area
// [RL10] config bit 3 enables external reset pin
// [RL11] config bit 4 enables debug, default one
// [RL12] config bit 7 zero blocks tool readout
// [RL13] bits 31..28 equal 0100b mark valid word
// [RL14] debug active: debug 1, reset 0, read 1
// [RL15] active debug owns both debug pins exclusively
// [RL16] inactive debug releases both pins to others
// [RL17] highest enabled alternate function wins, GPIO last
// [RL18] 24 bits, one per segment pin, 1 drives LCD
// [RL19] 0x20000000..0x20005fff is low retained bank
// [RL20] 0x20006000..0x200067ff is high retained bank
// [RL21] reserved holes answer error with zero data
// [RL22] bad marker falls back to all default fields
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module samabc_top
  import samabc_pkg::*;
#(
  parameter int NUM_ALT = 4
) (
  // clock, reset and enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // register bus, write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // register bus, write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // register bus, read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // processor or tool access to decode
  input wire logic cpu_req,
  input wire logic [31:0] cpu_addr,
  input wire logic cpu_write,
  input wire logic cpu_from_tool,
  input wire logic [31:0] tgt_rdata,
  // decode answer
  output logic cpu_resp,
  output logic cpu_resp_err,
  output logic [31:0] cpu_rdata,
  output samabc_region_type cpu_region,
  // stored configuration word from nv storage
  input wire logic [31:0] nv_cfg_word,
  input wire logic nv_cfg_load,
  // external manual reset pin, active low
  input wire logic ext_reset_pin_n,
  output logic ext_reset_req,
  // derived configuration
  output logic boot_enable,
  output logic readout_enable,
  output logic debug_active,
  // debug pins and shared pin mux
  output logic debug_clk_pin_owned,
  output logic debug_data_pin_owned,
  input wire logic [NUM_ALT-1:0] alt_req,
  output logic [NUM_ALT-1:0] alt_grant,
  output logic gpio_owned,
  // segment pin selection
  output logic [SEG_PINS-1:0] segment_pin_lcd_enable
);

  // ==========================================================
  // state record
  typedef struct packed {
    samabc_bus_type bus;
    logic aw_got;
    logic w_got;
    logic [3:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] cfg_word;
    logic [SEG_PINS-1:0] lcd_segment_pin_select;
    logic [NUM_ALT-1:0] alt_enable;
    logic [NUM_ALT-1:0] grant;
    logic gpio;
    logic resp;
    logic resp_err;
    logic [31:0] resp_data;
    samabc_region_type region;
    logic err_seen;
    logic [2:0] pin_sync;
    logic pin_level;
  } samabc_state_type;

  samabc_state_type st; // registered state
  samabc_state_type next_st; // next value
  samabc_cfg_type cfg; // effective configuration
  samabc_region_type rgn; // region of current access
  logic blocked; // access refused
  logic [NUM_ALT-1:0] alt_live; // requested and enabled
  logic [NUM_ALT-1:0] alt_pick; // lowest index set bit
  logic [31:0] rd_word; // register read value
  logic rd_ok; // read address mapped

  // ==========================================================
  // address classifier
  function automatic samabc_region_type classify(logic [31:0] a);
    samabc_region_type r;
    r = RGN_HOLE;
    // [RL1] code storage as four sub-areas
    if (a <= CODE_HI) begin
      // [RL5] user program area
      if (a <= PROG_HI) begin
        r = RGN_USER_PROG;
      // [RL6] user nv data area
      end else if (a >= NVDATA_LO && a <= NVDATA_HI) begin
        r = RGN_USER_DATA;
      // [RL7] boot program area
      end else if (a >= BOOT_LO && a <= BOOT_HI) begin
        r = RGN_BOOT;
      // [RL8] nv config info area
      end else if (a >= INFO_LO) begin
        r = RGN_CFG_INFO;
      end
    // [RL2] sram window split in two banks
    end else if (a >= SRAM_LO && a <= SRAM_HI) begin
      // [RL19] low retained bank
      if (a <= SRAM_LOW_HI) begin
        r = RGN_SRAM_LOW;
      // [RL20] high retained bank
      end else if (a >= SRAM_HIGH_LO) begin
        r = RGN_SRAM_HIGH;
      end
    // [RL3] peripheral space
    end else if (a >= PERIPH_LO && a <= PERIPH_HI) begin
      r = RGN_PERIPH;
    // [RL4] system control space
    end else if (a >= SCS_LO && a <= SCS_HI) begin
      r = RGN_SCS;
    end
    return r;
  endfunction

  // ==========================================================
  // configuration decode
  always_comb begin
    logic [31:0] w;
    w = st.cfg_word;
    // [RL13] marker check
    cfg.valid = (w[CFG_SIG_LSB +: 4] == CFG_SIG_VALUE);
    // [RL22] bad marker means default word
    if (!cfg.valid) begin
      w = CFG_DEFAULT;
    end
    // [RL10] reset pin enable
    cfg.reset_en = w[CFG_RESET_BIT];
    // [RL11] debug enable
    cfg.debug_en = w[CFG_DEBUG_BIT];
    // [RL12] readout permit
    cfg.read_en = w[CFG_READ_BIT];
    cfg.boot_en = w[CFG_BOOT_BIT];
  end

  // ==========================================================
  // access check for the decoder port
  always_comb begin
    rgn = classify(cpu_addr);
    blocked = 1'b0;
    // [RL21] holes reach nothing
    if (rgn == RGN_HOLE) begin
      blocked = 1'b1;
    end
    // [RL9] tool writes confined to user part of info area
    if (cpu_from_tool && cpu_write && rgn == RGN_CFG_INFO &&
        cpu_addr > INFO_USER_HI) begin
      blocked = 1'b1;
    end
    // [RL12] tool readout of user program and user nv data areas refused when protected
    if (cpu_from_tool && !cpu_write && !cfg.read_en &&
        (rgn == RGN_USER_PROG || rgn == RGN_USER_DATA)) begin
      blocked = 1'b1;
    end
  end

  // ==========================================================
  // shared pin priority, index zero ranks highest
  always_comb begin
    alt_live = alt_req & st.alt_enable;
    alt_pick = '0;
    // [RL17] scan from the top, last live function found (lowest index) wins
    for (int i = NUM_ALT - 1; i >= 0; i--) begin
      if (alt_live[i]) begin
        alt_pick = '0;
        alt_pick[i] = 1'b1;
      end
    end
  end

  // ==========================================================
  // register read mux
  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr[3:0])
      REG_CFG_STATUS: begin
        rd_word[0] = cfg.valid;
        rd_word[1] = cfg.reset_en;
        rd_word[2] = cfg.debug_en;
        rd_word[3] = cfg.read_en;
        rd_word[4] = cfg.boot_en;
        rd_word[5] = debug_active;
      end
      REG_LCD_SEG: begin
        rd_word[SEG_PINS-1:0] = st.lcd_segment_pin_select;
      end
      REG_ACCESS_STATUS: begin
        rd_word[3:0] = st.region;
        rd_word[4] = st.err_seen;
      end
      REG_ALT_ENABLE: begin
        rd_word[NUM_ALT-1:0] = st.alt_enable;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
    // only aligned words inside the block are mapped
    if (s_axi_araddr[31:4] != '0) begin
      rd_ok = 1'b0;
      rd_word = '0;
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    logic wr_ok;
    logic [31:0] merged;
    next_st = st;
    wr_ok = 1'b0;
    merged = '0;
    next_st.resp = 1'b0;
    // new stored word replaces the old one
    if (nv_cfg_load) begin
      next_st.cfg_word = nv_cfg_word;
    end
    // decoder answer one cycle after the request
    if (cpu_req) begin
      next_st.resp = 1'b1;
      next_st.resp_err = blocked;
      next_st.region = blocked ? RGN_HOLE : rgn;
      // [RL21] refused access reads zero
      next_st.resp_data = blocked ? '0 : tgt_rdata;
      // sticky until software clears, set wins
      next_st.err_seen = st.err_seen | blocked;
    end
    // reset pin filter: second and third stage agree
    next_st.pin_sync = {st.pin_sync[1:0], ext_reset_pin_n};
    if (st.pin_sync[1] == st.pin_sync[2]) begin
      next_st.pin_level = st.pin_sync[2];
    end
    // shared pin ownership outputs registered
    // [RL15] active debug takes the pins from everyone
    if (debug_active) begin
      next_st.grant = '0;
      next_st.gpio = 1'b0;
    // [RL16] released pins go to functions or GPIO
    end else begin
      next_st.grant = alt_pick;
      // [RL17] GPIO only when nothing else is live
      next_st.gpio = (alt_live == '0);
    end
    // capture write address and data in any order
    if (s_axi_awvalid && s_axi_awready) begin
      next_st.aw_got = 1'b1;
      next_st.waddr = s_axi_awaddr[3:0];
      if (s_axi_awaddr[31:4] != '0) begin
        next_st.waddr = 4'h1;
      end
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end
    unique case (st.bus)
      BUS_IDLE: begin
        if (st.aw_got && st.w_got) begin
          next_st.aw_got = 1'b0;
          next_st.w_got = 1'b0;
          next_st.bus = BUS_WRESP;
          for (int b = 0; b < 4; b++) begin
            merged[8*b +: 8] = st.wstrb[b] ?
              st.wdata[8*b +: 8] : 8'h00;
          end
          unique case (st.waddr)
            REG_LCD_SEG: begin
              wr_ok = 1'b1;
              for (int b = 0; b < 3; b++) begin
                if (st.wstrb[b]) begin
                  next_st.lcd_segment_pin_select[8*b +: 8] =
                    merged[8*b +: 8];
                end
              end
            end
            REG_ALT_ENABLE: begin
              wr_ok = 1'b1;
              if (st.wstrb[0]) begin
                next_st.alt_enable = merged[NUM_ALT-1:0];
              end
            end
            REG_ACCESS_STATUS: begin
              wr_ok = 1'b1;
              // write one clears, a blocked access now wins
              if (st.wstrb[0] && merged[4] && !(cpu_req && blocked)) begin
                next_st.err_seen = 1'b0;
              end
            end
            REG_CFG_STATUS: begin
              wr_ok = 1'b1;
            end
            default: begin
              wr_ok = 1'b0;
            end
          endcase
          next_st.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_arvalid) begin
          next_st.bus = BUS_RRESP;
          next_st.rdata = rd_word;
          next_st.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
        end
      end
      BUS_WRESP: begin
        if (s_axi_bready) begin
          next_st.bus = BUS_IDLE;
        end
      end
      BUS_RRESP: begin
        if (s_axi_rready) begin
          next_st.bus = BUS_IDLE;
        end
      end
    endcase
  end

  // ==========================================================
  // state register, frozen while ce is low unless aresetn is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.bus <= BUS_IDLE;
      st.region <= RGN_HOLE;
      st.cfg_word <= CFG_DEFAULT;
      st.pin_sync <= 3'h7;
      st.pin_level <= 1'b1;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  // handshakes: idle slave, nothing latched yet
  assign s_axi_awready = !st.aw_got && st.bus == BUS_IDLE && ce;
  assign s_axi_wready = !st.w_got && st.bus == BUS_IDLE && ce;
  assign s_axi_arready = st.bus == BUS_IDLE && !(st.aw_got && st.w_got)
    && ce;
  assign s_axi_bvalid = st.bus == BUS_WRESP;
  assign s_axi_bresp = st.bresp;
  assign s_axi_rvalid = st.bus == BUS_RRESP;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign cpu_resp = st.resp;
  assign cpu_resp_err = st.resp_err;
  assign cpu_rdata = st.resp_data;
  assign cpu_region = st.region;
  // [RL14] debug needs all three fields right
  assign debug_active = cfg.debug_en && !cfg.reset_en && cfg.read_en;
  // [RL15] both debug pins follow the debug state
  assign debug_clk_pin_owned = debug_active;
  assign debug_data_pin_owned = debug_active;
  assign alt_grant = st.grant;
  assign gpio_owned = st.gpio;
  // [RL10] pin ignored unless enabled
  assign ext_reset_req = cfg.reset_en && !st.pin_level;
  assign boot_enable = cfg.boot_en;
  assign readout_enable = cfg.read_en;
  // [RL18] one bit per segment pin
  assign segment_pin_lcd_enable = st.lcd_segment_pin_select;

endmodule

//--- samabc_asserts.sv
// assertion checker for the address map and boot config block
`timescale 1ns/10ps
module samabc_asserts
  import samabc_pkg::*;
#(
  parameter int NUM_ALT = 4
) (
  // clock, reset and enable
  input logic aclk,
  input logic aresetn,
  input logic ce,
  // decoder request and answer
  input logic cpu_req,
  input logic [31:0] cpu_addr,
  input logic cpu_write,
  input logic cpu_from_tool,
  input logic cpu_resp,
  input logic cpu_resp_err,
  input logic [31:0] cpu_rdata,
  input samabc_region_type cpu_region,
  // pin ownership
  input logic debug_active,
  input logic [NUM_ALT-1:0] alt_grant,
  input logic gpio_owned
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // helpers
  // true for any address outside every mapped window
  function automatic logic hole(logic [31:0] a);
    return !(a <= CODE_HI || a inside {[SRAM_LO:SRAM_HI]} ||
      a inside {[PERIPH_LO:PERIPH_HI]} || a inside {[SCS_LO:SCS_HI]});
  endfunction
  // a request taken at this edge that meets a condition
  sequence s_take(c);
    ce && cpu_req && c;
  endsequence
  // a clean answer naming one region
  sequence s_ok(samabc_region_type g);
    cpu_resp && !cpu_resp_err && cpu_region == g;
  endsequence
  // ==========================================================
  // decoder answers
  AST_RESP: assert property (s_take(1'h1) |=> cpu_resp)
    else $error("request left unanswered");
  AST_HOLE: assert property (s_take(hole(cpu_addr)) |=>
    cpu_resp_err && cpu_rdata == 32'h0 && cpu_region == RGN_HOLE)
    else $error("hole access not refused");
  AST_PROG: assert property (s_take(!cpu_from_tool &&
    cpu_addr <= PROG_HI) |=> s_ok(RGN_USER_PROG))
    else $error("program area misdecoded");
  AST_SRAM_LOW: assert property (s_take(cpu_addr inside
    {[SRAM_LO:SRAM_LOW_HI]}) |=> s_ok(RGN_SRAM_LOW))
    else $error("low bank misdecoded");
  AST_SRAM_HIGH: assert property (s_take(cpu_addr inside
    {[SRAM_HIGH_LO:SRAM_HI]}) |=> s_ok(RGN_SRAM_HIGH))
    else $error("high bank misdecoded");
  AST_PERIPH: assert property (s_take(cpu_addr inside
    {[PERIPH_LO:PERIPH_HI]}) |=> s_ok(RGN_PERIPH))
    else $error("peripheral space misdecoded");
  AST_SCS: assert property (s_take(cpu_addr inside
    {[SCS_LO:SCS_HI]}) |=> s_ok(RGN_SCS))
    else $error("system control space misdecoded");
  AST_INFO_LOCK: assert property (s_take(cpu_from_tool &&
    cpu_write && cpu_addr > INFO_USER_HI && cpu_addr <= CODE_HI)
    |=> cpu_resp_err)
    else $error("tool wrote system owned info");
  // ==========================================================
  // pin ownership
  AST_DBG_PINS: assert property (debug_active [*2] |->
    alt_grant == '0 && !gpio_owned)
    else $error("debug pins shared while debug active");
  AST_ONE_GRANT: assert property ($onehot0(alt_grant) &&
    !(gpio_owned && |alt_grant))
    else $error("shared pin granted twice");
endmodule

bind samabc_top samabc_asserts #(.NUM_ALT(NUM_ALT)) u_asserts (
  .aclk, .aresetn, .ce, .cpu_req, .cpu_addr, .cpu_write, .cpu_from_tool,
  .cpu_resp, .cpu_resp_err, .cpu_rdata, .cpu_region, .debug_active,
  .alt_grant, .gpio_owned);

//--- samabc_cpu_model.sv
// processor bus master model that issues decode requests
`timescale 1ns/10ps
module samabc_cpu_model (
  // clock and reset
  input logic aclk,
  input logic aresetn,
  // commands from the bench
  input logic go,
  input logic [31:0] addr,
  input logic wr,
  input logic tool,
  // request side of the decoder
  output logic cpu_req,
  output logic [31:0] cpu_addr,
  output logic cpu_write,
  output logic cpu_from_tool,
  output logic [31:0] tgt_rdata
);
  // one request per cycle; an idle bus keeps toggling so stale values show
  // tool writes go where the bench aims them, refusals on purpose
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_req <= 1'h0;
      cpu_addr <= 32'h0;
      tgt_rdata <= 32'h0;
    end else begin
      cpu_req <= go;
      cpu_addr <= go ? addr : ~cpu_addr;
      tgt_rdata <= go ? {addr[15:0], addr[31:16]} : ~tgt_rdata;
    end
    cpu_write <= wr;
    cpu_from_tool <= tool;
  end
endmodule

//--- samabc_tb_top.sv
// self-checking bench for the address map and boot config block
`timescale 1ns/10ps
module samabc_tb_top
  import samabc_pkg::*;
;
  // ==========================================================
  // signals
  logic aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cpu_req, cpu_write, cpu_from_tool, cpu_resp;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] cpu_addr, tgt_rdata, cpu_rdata, nv_cfg_word = 32'h0;
  logic cpu_resp_err, nv_cfg_load = 1'h0, ext_reset_pin_n = 1'h1;
  logic ext_reset_req, boot_enable, readout_enable, debug_active;
  logic debug_clk_pin_owned, debug_data_pin_owned, gpio_owned;
  logic go = 1'h0, wr = 1'h0, tool = 1'h0;
  logic [31:0] addr = 32'h0;
  logic [3:0] alt_req = 4'h0, alt_grant;
  logic [SEG_PINS-1:0] segment_pin_lcd_enable;
  samabc_region_type cpu_region;
  int miscompares = 0, n_compared = 0;
  logic exp_rd = 1'h1; // readout permission the model expects
  logic [65:0] q[$]; // in flight: tool, write, target data, address
  logic [31:0] bnd [25] = '{32'h0, 32'h6ffff, 32'h70000, 32'h77fff,
    32'h78000, 32'h7dfff, 32'h7e000, 32'h7eeff, 32'h7ef00, 32'h7ffff,
    32'h80000, 32'h1fffffff, 32'h20000000, 32'h20005fff, 32'h20006000,
    32'h200067ff, 32'h20006800, 32'h40000000, 32'h4000ffff, 32'h40010000,
    32'he000bfff, 32'he000c000, 32'he000ffff, 32'he0010000, 32'hffffffff};

  always #5 aclk = ~aclk;

  samabc_top #(.NUM_ALT(4)) u_dut (.aclk, .aresetn, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_req,
    .cpu_addr, .cpu_write, .cpu_from_tool, .tgt_rdata, .cpu_resp,
    .cpu_resp_err, .cpu_rdata, .cpu_region, .nv_cfg_word, .nv_cfg_load,
    .ext_reset_pin_n, .ext_reset_req, .boot_enable, .readout_enable,
    .debug_active, .debug_clk_pin_owned, .debug_data_pin_owned, .alt_req,
    .alt_grant, .gpio_owned, .segment_pin_lcd_enable);

  samabc_cpu_model u_cpu (.aclk, .aresetn, .go, .addr, .wr, .tool,
    .cpu_req, .cpu_addr, .cpu_write, .cpu_from_tool, .tgt_rdata);

  // ==========================================================
  // shared tasks
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] x);
    n_compared++;
    if (seen !== x) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, x, seen);
    end
  endtask

  task stop_test;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // both channels offered together; bready held up until the answer
  task automatic axi_wr(input logic [31:0] a, d, output logic [1:0] r);
    logic ta = 1'h0, tw = 1'h0, got = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!got) begin
      @(negedge aclk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      got = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ta, got;
    ta = 1'h0;
    got = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!got) begin
      @(negedge aclk);
      ta = ta | s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask

  task req(input logic [31:0] a, input logic w, input logic t);
    @(posedge aclk);
    go <= 1'h1;
    addr <= a;
    wr <= w;
    tool <= t;
  endtask

  task load(input logic [31:0] w);
    @(posedge aclk);
    go <= 1'h0;
    nv_cfg_word <= w;
    nv_cfg_load <= 1'h1;
    @(posedge aclk);
    nv_cfg_load <= 1'h0;
  endtask

  // reference decode of one address, 0 for a hole
  function automatic int rgn(logic [31:0] a);
    if (a <= PROG_HI) return 1;
    if (a <= NVDATA_HI) return 2;
    if (a <= BOOT_HI) return 3;
    if (a <= CODE_HI) return 4;
    if (a inside {[SRAM_LO:SRAM_LOW_HI]}) return 5;
    if (a inside {[SRAM_HIGH_LO:SRAM_HI]}) return 6;
    if (a inside {[PERIPH_LO:PERIPH_HI]}) return 7;
    if (a inside {[SCS_LO:SCS_HI]}) return 8;
    return 0;
  endfunction

  // ==========================================================
  // decoder scoreboard: queue at the request, compare at the answer
  always @(posedge aclk)
    if (aresetn && cpu_req)
      q.push_back({cpu_from_tool, cpu_write, tgt_rdata, cpu_addr});

  always @(negedge aclk) begin
    logic [65:0] e;
    int r;
    logic er;
    if (cpu_resp === 1'h1 && q.size() > 0) begin
      e = q.pop_front();
      r = rgn(e[31:0]);
      er = r == 0 || (e[65] && e[64] && e[31:0] > INFO_USER_HI &&
        e[31:0] <= CODE_HI) || (e[65] && !e[64] && !exp_rd && r inside {1, 2});
      chk("err", cpu_resp_err, er);
      chk("region", cpu_region, er ? 0 : r);
      if (!e[64] || er)
        chk("rdata", cpu_rdata, er ? 32'h0 : e[63:32]);
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] d, w;
    logic [1:0] r;
    logic [3:0] m, en;
    logic rs, dg, bt, rd, v, dbg;
    int n;
    void'($urandom(78736));
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    axi_rd(32'(REG_CFG_STATUS), d, r);
    chk("cfg", d[5:0], 6'h3d);
    axi_rd(32'(REG_LCD_SEG), d, r);
    chk("seg", d, 32'h0);
    w = $urandom;
    axi_wr(32'(REG_LCD_SEG), w, r);
    axi_rd(32'(REG_LCD_SEG), d, r);
    chk("seg", d, {8'h0, w[23:0]});
    chk("pins", segment_pin_lcd_enable, w[23:0]);
    axi_wr(32'h10, w, r);
    chk("bresp", r, RESP_SLVERR);
    axi_rd(32'h10, d, r);
    chk("rresp", {r, d}, {RESP_SLVERR, 32'h0});
    $display("registers test done");
    foreach (bnd[i]) req(bnd[i], 1'($urandom), 1'($urandom));
    repeat (40)
      req(bnd[$urandom_range(24)] + 32'($urandom_range(8)) - 32'h4,
        1'($urandom), 1'($urandom));
    req(32'h80000, 1'h0, 1'h0);
    @(posedge aclk);
    go <= 1'h0;
    axi_rd(32'(REG_ACCESS_STATUS), d, r);
    chk("status", d[4:0], 5'h10);
    axi_wr(32'(REG_ACCESS_STATUS), 32'h10, r);
    axi_rd(32'(REG_ACCESS_STATUS), d, r);
    chk("status", d[4], 1'h0);
    $display("decode test done");
    ext_reset_pin_n <= 1'h0;
    for (int i = 0; i < 10; i++) begin
      v = i < 8;
      w = $urandom;
      w[3] = i[0];
      w[4] = i[1];
      w[7] = i[2];
      w[31:28] = v ? 4'h4 : 4'h9;
      rs = v & w[3];
      dg = !v | w[4];
      bt = !v | w[6];
      rd = !v | w[7];
      dbg = dg & !rs & rd;
      load(w);
      exp_rd = rd;
      n = 0;
      do begin
        @(negedge aclk);
        n++;
      end while (ext_reset_req !== rs && n < 12);
      chk("rst", ext_reset_req, rs);
      chk("dbg", debug_active, dbg);
      chk("own", {debug_clk_pin_owned, debug_data_pin_owned}, {2{dbg}});
      chk("rd", readout_enable, rd);
      chk("boot", boot_enable, bt);
      axi_rd(32'(REG_CFG_STATUS), d, r);
      chk("cfg", d[5:0], {dbg, bt, rd, dg, rs, v});
      req(32'h100, 1'h0, 1'h1);
      req(32'h70010, 1'h0, 1'h1);
      req(32'h7ef00, 1'h1, 1'h1);
      req(32'h7eeff, 1'h1, 1'h1);
    end
    $display("config test done");
    load(32'h4000_0088);
    exp_rd = 1'h1;
    for (int k = 0; k < 2; k++) begin
      en = k ? 4'h6 : 4'hf;
      axi_wr(32'(REG_ALT_ENABLE), {28'h0, en}, r);
      repeat (8) begin
        @(posedge aclk);
        alt_req <= 4'($urandom);
        @(posedge aclk);
        @(negedge aclk);
        m = alt_req & en;
        chk("grant", alt_grant, m & (~m + 4'h1));
        chk("gpio", gpio_owned, m == 4'h0);
      end
    end
    load(CFG_DEFAULT);
    alt_req <= 4'hf;
    @(posedge aclk);
    @(negedge aclk);
    chk("held", {alt_grant, gpio_owned}, 5'h0);
    $display("pin priority test done");
    stop_test;
  end

  // watchdog sized well beyond the few hundred cycles the tests take
  initial begin
    #300us;
    miscompares++;
    $display("watchdog expired");
    stop_test;
  end
endmodule
